// File: rtl/bridge_control_decode.sv
// Bridge control register with secondary reset and legacy display routing
`include "bridge_control_params.svh"

module bridge_control_decode (
    input  wire logic        clock_i,
    input  wire logic        reset_i,
    input  wire logic        clock_enable_i,
    // Configuration access
    input  wire logic        cfg_write_i,
    input  wire logic        cfg_read_i,
    input  wire logic [7:0]  cfg_addr_i,
    input  wire logic [1:0]  cfg_byte_en_i,
    input  wire logic [15:0] cfg_wdata_i,
    output logic      [15:0] cfg_rdata_o,
    output logic             cfg_rvalid_o,
    // Command register qualifiers
    input  wire logic        io_enable_i,
    input  wire logic        mem_enable_i,
    // Transaction to be routed
    input  wire logic        req_valid_i,
    input  wire logic        req_is_io_i,
    input  wire logic        req_from_secondary_i,
    input  wire logic [31:0] req_addr_i,
    output logic             route_valid_o,
    output logic             route_claim_o,
    output logic             route_block_o,
    // Downstream link reset
    output logic             secondary_bus_reset_o,
    output logic             train_reset_start_o
);

    // ------------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------------
    // Mask and reset vector as indexable constants, one bit picked per flop
    localparam logic [`BRIDGE_CTRL_WIDTH-1:0] ctrl_wmask       = `BRIDGE_CTRL_WMASK;
    localparam logic [`BRIDGE_CTRL_WIDTH-1:0] ctrl_reset_value = `BRIDGE_CTRL_RESET;

    logic [`BRIDGE_CTRL_WIDTH-1:0] ctrl_reg;
    logic                          ctrl_hit;
    logic                          ctrl_write;
    logic [1:0]                    lane_write;

    assign ctrl_hit   = (cfg_addr_i == `BRIDGE_CTRL_OFFSET);
    assign ctrl_write = clock_enable_i && cfg_write_i && ctrl_hit;

    // Per-lane strobe; the upper lane reaches no writable bit
    assign lane_write = {2{ctrl_write}} & cfg_byte_en_i;

    // One flop per writable bit; read-only bits are tied off, so reserved
    // and hardwired fields always read zero whatever is written.
    genvar bit_idx;
    generate
        for (bit_idx = 0; bit_idx < `BRIDGE_CTRL_WIDTH; bit_idx++) begin : g_bit
            if (ctrl_wmask[bit_idx]) begin : g_rw
                logic field_reg;

                always_ff @(posedge clock_i) begin
                    if (reset_i) begin
                        field_reg <= ctrl_reset_value[bit_idx];
                    end else if (lane_write[bit_idx / `BYTE_WIDTH]) begin
                        field_reg <= cfg_wdata_i[bit_idx];
                    end
                end

                assign ctrl_reg[bit_idx] = field_reg;
            end else begin : g_ro
                assign ctrl_reg[bit_idx] = 1'b0;
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Field views
    // ------------------------------------------------------------------------
    logic sec_reset_bit;
    logic full_decode_bit;
    logic display_en_bit;

    assign sec_reset_bit   = ctrl_reg[`BIT_SEC_RESET];
    assign full_decode_bit = ctrl_reg[`BIT_FULL_DECODE];
    assign display_en_bit  = ctrl_reg[`BIT_DISPLAY_EN];

    // ------------------------------------------------------------------------
    // Read return
    // ------------------------------------------------------------------------
    logic [`BRIDGE_CTRL_WIDTH-1:0] read_word;

    // Unmatched offsets still answer, with zero, so a config read never hangs
    always_comb begin
        case (cfg_addr_i)
            `BRIDGE_CTRL_OFFSET: begin
                read_word = ctrl_reg;
            end
            default: begin
                read_word = `BRIDGE_CTRL_RESET;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            cfg_rdata_o <= `BRIDGE_CTRL_RESET;
        end else if (clock_enable_i && cfg_read_i) begin
            cfg_rdata_o <= read_word;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            cfg_rvalid_o <= 1'b0;
        end else if (clock_enable_i) begin
            cfg_rvalid_o <= cfg_read_i;
        end
    end

    // ------------------------------------------------------------------------
    // Secondary bus reset sequencing
    // ------------------------------------------------------------------------
    bridge_control_pkg::link_state_t link_state_reg;
    bridge_control_pkg::link_state_t link_state_next;

    always_comb begin
        link_state_next = link_state_reg;
        case (link_state_reg)
            bridge_control_pkg::link_active: begin
                if (sec_reset_bit) begin
                    link_state_next = bridge_control_pkg::link_hot_reset;
                end
            end
            bridge_control_pkg::link_hot_reset: begin
                if (!sec_reset_bit) begin
                    link_state_next = bridge_control_pkg::link_active;
                end
            end
            default: begin
                link_state_next = bridge_control_pkg::link_active;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            link_state_reg <= bridge_control_pkg::link_active;
        end else if (clock_enable_i) begin
            link_state_reg <= link_state_next;
        end
    end

    // ------------------------------------------------------------------------
    // Link reset outputs
    // ------------------------------------------------------------------------
    // Held level: the port stays in reset for as long as the bit is one
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            secondary_bus_reset_o <= 1'b0;
        end else if (clock_enable_i) begin
            secondary_bus_reset_o <= (link_state_next == bridge_control_pkg::link_hot_reset);
        end
    end

    logic enter_reset;

    // Entry edge only: holding the bit high must not retrigger training
    assign enter_reset = (link_state_reg == bridge_control_pkg::link_active)
                      && (link_state_next == bridge_control_pkg::link_hot_reset);

    // Single pulse tells the link trainer to start the reset sequence
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            train_reset_start_o <= 1'b0;
        end else if (clock_enable_i) begin
            train_reset_start_o <= enter_reset;
        end
    end

    // ------------------------------------------------------------------------
    // Legacy display routing
    // ------------------------------------------------------------------------
    logic addr_hit;
    logic display_hit;
    logic space_enabled;
    logic claim_next;
    logic block_next;

    legacy_display_decode u_decode (
        .addr_i        (req_addr_i),
        .is_io_i       (req_is_io_i),
        .full_decode_i (full_decode_bit),
        .hit_o         (addr_hit)
    );

    // Enable gates the whole match, so full decode alone does nothing
    assign display_hit   = display_en_bit && addr_hit;
    assign space_enabled = req_is_io_i ? io_enable_i : mem_enable_i;

    // Base/limit windows are not consulted for these addresses
    assign claim_next = display_hit && !req_from_secondary_i && space_enabled;
    assign block_next = display_hit && req_from_secondary_i;

    // ------------------------------------------------------------------------
    // Route outputs
    // ------------------------------------------------------------------------
    // Decided against this cycle's register value; a config write in the same
    // cycle only steers the requests that follow it.
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            route_valid_o <= 1'b0;
        end else if (clock_enable_i) begin
            route_valid_o <= req_valid_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            route_claim_o <= 1'b0;
        end else if (clock_enable_i) begin
            route_claim_o <= req_valid_i && claim_next;
        end
    end

    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            route_block_o <= 1'b0;
        end else if (clock_enable_i) begin
            route_block_o <= req_valid_i && block_next;
        end
    end

endmodule

// File: common/bridge_control_params.svh
// Constants for the bridge control register and legacy display decode
`ifndef BRIDGE_CONTROL_PARAMS_SVH
`define BRIDGE_CONTROL_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register location and layout
// ----------------------------------------------------------------------------
`define BRIDGE_CTRL_OFFSET   8'h3e
`define BRIDGE_CTRL_RESET    16'h0000
`define BRIDGE_CTRL_WMASK    16'h005f
`define BRIDGE_CTRL_WIDTH    16
`define BIT_SEC_RESET        6
`define BIT_FULL_DECODE      4
`define BIT_DISPLAY_EN       3
`define BYTE_WIDTH           8

// ----------------------------------------------------------------------------
// Legacy display address windows
// ----------------------------------------------------------------------------
`define LEGACY_MEM_LO        32'h000a_0000
`define LEGACY_MEM_HI        32'h000b_ffff
`define IO_HIGH_MSB          31
`define IO_HIGH_LSB          16
`define IO_HIGH_ZERO         16'h0000
`define IO_ALIAS_MSB         15
`define IO_ALIAS_LSB         10
`define IO_ALIAS_ZERO        6'h00
`define IO_OFFS_MSB          9
`define IO_MONO_LO           10'h3b0
`define IO_MONO_HI           10'h3bb
`define IO_COLOR_LO          10'h3c0
`define IO_COLOR_HI          10'h3df

`endif

// File: common/bridge_control_pkg.sv
// Types shared by the bridge control register bank
package bridge_control_pkg;
    typedef enum logic {
        link_active,
        link_hot_reset
    } link_state_t;
endpackage

// File: rtl/legacy_display_decode.sv
// Combinational matcher for legacy display memory and I/O addresses
`include "bridge_control_params.svh"

module legacy_display_decode (
    input  wire logic [31:0] addr_i,
    input  wire logic        is_io_i,
    input  wire logic        full_decode_i,
    output logic             hit_o
);
    logic [`IO_OFFS_MSB:0] offs;
    logic                  mem_hit;
    logic                  io_hit;
    logic                  alias_ok;

    assign offs = addr_i[`IO_OFFS_MSB:0];

    // Inclusive window on the full 32-bit address
    assign mem_hit = (addr_i >= `LEGACY_MEM_LO) && (addr_i <= `LEGACY_MEM_HI);

    // Without full decode any alias of bits 15:10 is taken
    assign alias_ok = !full_decode_i
                   || (addr_i[`IO_ALIAS_MSB:`IO_ALIAS_LSB] == `IO_ALIAS_ZERO);

    assign io_hit = (addr_i[`IO_HIGH_MSB:`IO_HIGH_LSB] == `IO_HIGH_ZERO)
                 && alias_ok
                 && (((offs >= `IO_MONO_LO) && (offs <= `IO_MONO_HI))
                  || ((offs >= `IO_COLOR_LO) && (offs <= `IO_COLOR_HI)));

    assign hit_o = is_io_i ? io_hit : mem_hit;
endmodule

// File: bench/bridge_control_assertions.sv
// Port checks for the bridge control register bank
module bridge_control_assertions (
    input  wire logic        clock_i,
    input  wire logic        reset_i,
    input  wire logic        clock_enable_i,
    input  wire logic        cfg_write_i,
    input  wire logic        cfg_read_i,
    input  wire logic [7:0]  cfg_addr_i,
    input  wire logic [1:0]  cfg_byte_en_i,
    input  wire logic [15:0] cfg_wdata_i,
    input  wire logic [15:0] cfg_rdata_o,
    input  wire logic        cfg_rvalid_o,
    input  wire logic        req_valid_i,
    input  wire logic        req_from_secondary_i,
    input  wire logic        route_valid_o,
    input  wire logic        route_claim_o,
    input  wire logic        route_block_o,
    input  wire logic        secondary_bus_reset_o,
    input  wire logic        train_reset_start_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);
    read_answer_a: assert property (
        !reset_i && clock_enable_i && cfg_read_i |=> cfg_rvalid_o) else $error("no read answer");
    reserved_zero_a: assert property (
        cfg_rvalid_o |-> cfg_rdata_o[15:7] == 9'h000 && !cfg_rdata_o[5]) else $error("ro bit set");
    unmapped_zero_a: assert property (
        !reset_i && clock_enable_i && cfg_read_i && cfg_addr_i != 8'h3e
        |=> cfg_rdata_o == 16'h0000) else $error("unmapped read not zero");
    reset_level_a: assert property (
        !reset_i && clock_enable_i && cfg_write_i && cfg_addr_i == 8'h3e && cfg_byte_en_i[0]
        ##1 clock_enable_i |=> secondary_bus_reset_o == $past(cfg_wdata_i[6], 2))
        else $error("reset level wrong");
    reset_pulse_a: assert property (
        train_reset_start_o && $past(clock_enable_i)
        |-> secondary_bus_reset_o && !$past(secondary_bus_reset_o)) else $error("bad start");
    route_answer_a: assert property (
        !reset_i && clock_enable_i |=> route_valid_o == $past(req_valid_i))
        else $error("route answer wrong");
    claim_side_a: assert property (
        route_claim_o && $past(clock_enable_i)
        |-> route_valid_o && !$past(req_from_secondary_i)) else $error("claim side wrong");
    block_side_a: assert property (
        route_block_o && $past(clock_enable_i)
        |-> route_valid_o && $past(req_from_secondary_i)) else $error("block side wrong");
endmodule

bind bridge_control_decode bridge_control_assertions checker_i (
    .clock_i, .reset_i, .clock_enable_i, .cfg_write_i, .cfg_read_i, .cfg_addr_i,
    .cfg_byte_en_i, .cfg_wdata_i, .cfg_rdata_o, .cfg_rvalid_o, .req_valid_i,
    .req_from_secondary_i, .route_valid_o, .route_claim_o, .route_block_o,
    .secondary_bus_reset_o, .train_reset_start_o
);

// File: bench/downstream_device_model.sv
// Downstream device that counts link training resets
module downstream_device_model (
    input  wire logic       clock_i,
    input  wire logic       reset_i,
    input  wire logic       hot_reset_i,
    output logic      [7:0] resets_seen_o
);
    timeunit 1ns;
    timeprecision 100ps;
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            resets_seen_o <= 8'h00;
        end else if (hot_reset_i) begin
            resets_seen_o <= resets_seen_o + 8'h01;
        end
    end
endmodule

// File: bench/tb_bridge_control_decode.sv
// Self-checking bench for the bridge control register and display routing
module tb_bridge_control_decode;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clock_i = 1'b0, reset_i = 1'b1, ce = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
    logic        io_en = 1'b0, mem_en = 1'b0, rq = 1'b0, rq_io = 1'b0, rq_sec = 1'b0;
    logic [7:0]  addr = 8'h00, seen;
    logic [1:0]  be = 2'h0;
    logic [15:0] wdata = 16'h0000, rdata;
    logic [31:0] rq_addr = 32'h0;
    logic        rvalid, r_valid, r_claim, r_block, sbr, start, ven, fd;
    int          err_count = 0, check_count = 0, cycles = 0;
    logic [31:0] tbl [12] = '{32'h0009_ffff, 32'h000a_0000, 32'h000b_ffff, 32'h000c_0000,
        32'h3af, 32'h3b0, 32'h3bb, 32'h3bc, 32'h3c0, 32'h3df, 32'hfbdf, 32'h0001_03c0};
    always #5 clock_i = ~clock_i;
    bridge_control_decode dut (.clock_i, .reset_i, .clock_enable_i(ce), .cfg_write_i(wr_en),
        .cfg_read_i(rd_en), .cfg_addr_i(addr), .cfg_byte_en_i(be), .cfg_wdata_i(wdata),
        .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid), .io_enable_i(io_en), .mem_enable_i(mem_en),
        .req_valid_i(rq), .req_is_io_i(rq_io), .req_from_secondary_i(rq_sec),
        .req_addr_i(rq_addr), .route_valid_o(r_valid), .route_claim_o(r_claim),
        .route_block_o(r_block), .secondary_bus_reset_o(sbr), .train_reset_start_o(start));
    downstream_device_model link_peer (.clock_i, .reset_i, .hot_reset_i(start),
        .resets_seen_o(seen));
    task automatic finish_test;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc;
        @(posedge clock_i);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [1:0] b, input logic [15:0] d);
        addr = a; be = b; wdata = d; wr_en = 1'b1;
        cyc;
        wr_en = 1'b0;
        cyc;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        addr = a; rd_en = 1'b1;
        cyc;
        rd_en = 1'b0;
        chk(rvalid, 1'b1);
        chk(rdata, exp);
        cyc;
    endtask
    task automatic req(input logic io, input logic sec, input logic [31:0] a);
        logic hit;
        rq = 1'b1; rq_io = io; rq_sec = sec; rq_addr = a;
        hit = io ? a[31:16] == 16'h0 && (!fd || a[15:10] == 6'h00)
            && a[9:0] inside {[10'h3b0:10'h3bb], [10'h3c0:10'h3df]}
            : a inside {[32'h000a_0000:32'h000b_ffff]};
        cyc;
        chk(r_valid, 1'b1);
        chk(r_claim, ven && hit && !sec && (io ? io_en : mem_en));
        chk(r_block, ven && hit && sec);
    endtask
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            finish_test;
        end
    end
    initial begin
        repeat (2) cyc;
        reset_i = 1'b0;
        rd(8'h3e, 16'h0000);
        wr(8'h3e, 2'h3, 16'hffff);
        rd(8'h3e, 16'h005f);
        wr(8'h3e, 2'h2, 16'h0000);
        wr(8'h3c, 2'h3, 16'h0000);
        rd(8'h3c, 16'h0000);
        rd(8'h3e, 16'h005f);
        chk(seen, 8'h01);
        wr(8'h3e, 2'h1, 16'h0040);
        wr(8'h3e, 2'h1, 16'h0000);
        chk(sbr, 1'b0);
        wr(8'h3e, 2'h1, 16'h0040);
        chk(sbr, 1'b1);
        chk(start, 1'b1);
        cyc;
        chk(seen, 8'h02);
        chk(start, 1'b0);
        ce = 1'b0;
        wr(8'h3e, 2'h1, 16'h0000);
        ce = 1'b1;
        rd(8'h3e, 16'h0040);
        for (int m = 0; m < 8; m++) begin
            ven = m[0]; fd = m[1]; io_en = m[2]; mem_en = !m[2];
            wr(8'h3e, 2'h1, {11'h000, fd, ven, 3'h0});
            for (int i = 0; i < 24; i++) req(i % 12 > 3, i > 11, tbl[i % 12]);
            rq = 1'b0;
        end
        chk(sbr, 1'b0);
        chk(seen, 8'h02);
        finish_test;
    end
endmodule
